//--- src/i2s_audio_params.svh
/*
  constants for the dual audio serial port: timing figures, frame lengths,
  divider defaults and word widths.
  assumes it is included by bare name from src/ files; definitions only.
*/
// Functional notes
// - two independent ports, each with own pins
// - master drives clock and select; slave receives
// - serial data out always driven
// - sixteen-bit left and right words
// - left word msb fills first slot (code: second slot, one clock after select falls)
// - msb one clock after select edge, falling
// - left while select low, right while high
// - 32-bit frame at 48 kHz: 1.536 MHz
// - 50-bit frame at 48 kHz: 2.400 MHz
// - master clock from reference via N/M divider
// - master clock keeps fixed mark/space ratio (code: half periods differ by up to one core cycle)
`ifndef I2S_AUDIO_PARAMS_SVH
`define I2S_AUDIO_PARAMS_SVH

`define I2S_PORT_COUNT      2
`define I2S_WORD_BITS       16
`define I2S_CNT_BITS        6
`define I2S_FRAME_SHORT     6'd32
`define I2S_FRAME_LONG      6'd50
`define I2S_CORE_HZ         250000000
`define I2S_SAMPLE_HZ       48000
`define I2S_SLAVE_MAX_HZ    3072000
// divider defaults: bclk*2 = core * N / M (toggle rate)
`define I2S_DIV_N_SHORT     16'd192
`define I2S_DIV_M_SHORT     16'd15625
// 250 MHz * 12 / 625 = 4.8 M toggles: exactly 2.400 MHz, no rate drift
`define I2S_DIV_N_LONG      16'd12
`define I2S_DIV_M_LONG      16'd625
`define I2S_DIV_BITS        16

`endif

//--- src/i2s_audio_pkg.sv
/*
  types shared by the audio serial port files.
  assumes the params header is compiled alongside.
*/
package i2s_audio_pkg;
  typedef enum logic {MODE_SLAVE, MODE_MASTER} port_mode_t;
  typedef logic [15:0] sample_t;
endpackage

//--- src/i2s_audio_port.sv
/*
  dual audio serial port top: two independent ports, each master or slave.
  master: bit clock from core clock by an N/M accumulator, select generated.
  slave: bit clock and select arrive on pins and are synchronised.
  assumes core_clk at 250 MHz, well above eight times any slave bit clock.
*/
`timescale 1ns/1ps
`include "i2s_audio_params.svh"
module i2s_audio_port
  import i2s_audio_pkg::*;
#(
  parameter int PORTS = `I2S_PORT_COUNT
)
(
  input  wire logic                             core_clk,
  input  wire logic                             rst_n,
  input  wire logic [PORTS-1:0]                 master_en,
  input  wire logic [PORTS-1:0]                 long_frame,
  input  wire logic [PORTS-1:0][`I2S_DIV_BITS-1:0] div_n,
  input  wire logic [PORTS-1:0][`I2S_DIV_BITS-1:0] div_m,
  input  wire logic [PORTS-1:0]                 sck_in,
  output logic      [PORTS-1:0]                 sck_out,
  output logic      [PORTS-1:0]                 sck_oe,
  input  wire logic [PORTS-1:0]                 ws_in,
  output logic      [PORTS-1:0]                 ws_out,
  output logic      [PORTS-1:0]                 ws_oe,
  output logic      [PORTS-1:0]                 sdo,
  output logic      [PORTS-1:0]                 sdo_oe,
  input  wire logic [PORTS-1:0]                 sdi,
  input  wire sample_t [PORTS-1:0]              tx_left,
  input  wire sample_t [PORTS-1:0]              tx_right,
  output logic      [PORTS-1:0]                 tx_take,
  output sample_t   [PORTS-1:0]                 rx_left,
  output sample_t   [PORTS-1:0]                 rx_right,
  output logic      [PORTS-1:0]                 rx_valid
);

  // one decode of the mode, shared by divider, strobes and pin enables,
  // so the three can never disagree about who owns the clock
  function automatic logic is_master(input port_mode_t m);
    return (m == MODE_MASTER);
  endfunction

  // one independent copy per port
  for (genvar p = 0; p < PORTS; p++)
  begin : g_port
    i2s_lane_if lnk ();
    port_mode_t mode;                  // decoded mode
    logic [2:0] sck_s_r, sck_s_nxt;    // sync pair plus edge history
    logic [1:0] ws_s_r, ws_s_nxt;      // select sync pair
    logic [1:0] sdi_s_r, sdi_s_nxt;    // data sync pair
    logic [`I2S_DIV_BITS:0] acc_r, acc_nxt;  // fractional accumulator
    logic       mck_r, mck_nxt;        // generated bit clock
    logic [5:0] fcnt_r, fcnt_nxt;      // bit position in master half frame
    logic       mws_r, mws_nxt;        // generated select
    logic [5:0] half;                  // half frame length
    logic       tick;                  // accumulator overflow

    assign mode = master_en[p] ? MODE_MASTER : MODE_SLAVE;
    // 32-bit frame splits 16/16, 50-bit frame 25/25
    assign half = long_frame[p] ? (`I2S_FRAME_LONG >> 1)
                                : (`I2S_FRAME_SHORT >> 1);

    // next values: pin sync, divider and frame counter
    always_comb
    begin
      sck_s_nxt = {sck_s_r[1:0], sck_in[p]};
      ws_s_nxt  = {ws_s_r[0], ws_in[p]};
      sdi_s_nxt = {sdi_s_r[0], sdi[p]};
      // toggle the clock on each N/M overflow: half periods within one core cycle
      acc_nxt = {1'b0, acc_r[`I2S_DIV_BITS-1:0]} + {1'b0, div_n[p]};
      tick    = acc_nxt >= {1'b0, div_m[p]};
      if (tick)
        acc_nxt = acc_nxt - {1'b0, div_m[p]};
      mck_nxt  = mck_r;
      fcnt_nxt = fcnt_r;
      mws_nxt  = mws_r;
      // slave: divider parked so a later switch starts from a clean phase
      if (!is_master(mode))
      begin
        acc_nxt  = '0;
        mck_nxt  = 1'b0;
        fcnt_nxt = 6'd0;
        mws_nxt  = 1'b0;
      end
      else if (tick)
      begin
        mck_nxt = ~mck_r;
        // select changes on falling edge, one half frame each
        if (mck_r)
        begin
          if (fcnt_r == half - 6'd1)
          begin
            fcnt_nxt = 6'd0;
            mws_nxt  = ~mws_r;
          end
          else
            fcnt_nxt = fcnt_r + 6'd1;
        end
      end
    end

    // register the sync chains and divider
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        sck_s_r <= '0;
        ws_s_r  <= '0;
        sdi_s_r <= '0;
        acc_r   <= '0;
        mck_r   <= 1'b0;
        fcnt_r  <= 6'd0;
        mws_r   <= 1'b0;
      end
      else
      begin
        sck_s_r <= sck_s_nxt;
        ws_s_r  <= ws_s_nxt;
        sdi_s_r <= sdi_s_nxt;
        acc_r   <= acc_nxt;
        mck_r   <= mck_nxt;
        fcnt_r  <= fcnt_nxt;
        mws_r   <= mws_nxt;
      end
    end

    // edge strobes from generated clock or from synced pin (bits 1,2 only)
    always_comb
    begin
      // master strobes come a cycle ahead of the pin, in step with sdo
      if (is_master(mode))
      begin
        lnk.rise = tick && !mck_r;
        lnk.fall = tick && mck_r;
        lnk.ws   = mws_r;
      end
      else
      begin
        lnk.rise = sck_s_r[1] && !sck_s_r[2];
        lnk.fall = !sck_s_r[1] && sck_s_r[2];
        lnk.ws   = ws_s_r[1];
      end
      lnk.sdi = sdi_s_r[1];
    end

    i2s_lane u_lane (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .lnk      (lnk),
      .tx_left  (tx_left[p]),
      .tx_right (tx_right[p]),
      .tx_take  (tx_take[p]),
      .rx_left  (rx_left[p]),
      .rx_right (rx_right[p]),
      .rx_valid (rx_valid[p])
    );

    // pin drivers: clock and select out only in master
    assign sck_out[p] = mck_r;
    assign ws_out[p]  = mws_r;
    assign sck_oe[p]  = is_master(mode);
    assign ws_oe[p]   = is_master(mode);
    assign sdo[p]     = lnk.sdo;
    assign sdo_oe[p]  = 1'b1;
  end

endmodule

//--- src/i2s_lane.sv
/*
  one port's serial engine: shifts the transmit words out on falling edges
  and captures receive words on rising edges, aligned to word select.
  assumes edge strobes are one core cycle wide, on core_clk.
*/
`timescale 1ns/1ps
`include "i2s_audio_params.svh"
module i2s_lane
  import i2s_audio_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    rst_n,
  i2s_lane_if.lane     lnk,
  input  wire sample_t tx_left,
  input  wire sample_t tx_right,
  output logic         tx_take,
  output sample_t      rx_left,
  output sample_t      rx_right,
  output logic         rx_valid
);
  logic [5:0] bit_r, bit_nxt;       // bits since last select edge
  logic       ws_r, ws_nxt;         // select level seen at last rise
  sample_t    tsh_r, tsh_nxt;       // transmit shifter
  sample_t    rsh_r, rsh_nxt;       // receive shifter
  sample_t    rl_r, rl_nxt;         // held left word
  sample_t    rr_r, rr_nxt;         // held right word
  logic       sdo_r, sdo_nxt;       // data out register
  logic       rv_r, rv_nxt;         // received frame strobe
  logic       tk_r, tk_nxt;         // transmit words taken strobe

  // next state of the serial engine
  always_comb
  begin
    bit_nxt = bit_r;
    ws_nxt  = ws_r;
    tsh_nxt = tsh_r;
    rsh_nxt = rsh_r;
    rl_nxt  = rl_r;
    rr_nxt  = rr_r;
    sdo_nxt = sdo_r;
    rv_nxt  = 1'b0;
    tk_nxt  = 1'b0;
    if (lnk.rise)
    begin
      // receiver captures on rising edge; the lsb of a 16-slot half rides
      // the slot in which select has already flipped, so shift first
      if (bit_r < 6'(`I2S_WORD_BITS))
        rsh_nxt = {rsh_r[14:0], lnk.sdi};
      if (lnk.ws != ws_r)
      begin
        bit_nxt = 6'd0;
        ws_nxt  = lnk.ws;
        if (ws_r)
        begin
          // right half ended: frame complete
          rr_nxt = rsh_nxt;
          rv_nxt = 1'b1;
        end
        else
          rl_nxt = rsh_nxt;
      end
      else if (bit_r < 6'd63)
        bit_nxt = bit_r + 6'd1;
    end
    if (lnk.fall)
    begin
      // change data on falling edge; slot after select edge carries msb
      if (bit_r == 6'd0)
      begin
        tsh_nxt = ws_r ? tx_right : tx_left;
        tk_nxt  = ws_r;
        sdo_nxt = ws_r ? tx_right[15] : tx_left[15];
        tsh_nxt = {tsh_nxt[14:0], 1'b0};
      end
      else if (bit_r < 6'(`I2S_WORD_BITS))
      begin
        sdo_nxt = tsh_r[15];
        tsh_nxt = {tsh_r[14:0], 1'b0};
      end
      else
        sdo_nxt = 1'b0;
    end
  end

  // register the engine
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bit_r <= 6'd63;
      // select idles low; a high value here would fake an edge
      ws_r  <= 1'b0;
      tsh_r <= '0;
      rsh_r <= '0;
      rl_r  <= '0;
      rr_r  <= '0;
      sdo_r <= 1'b0;
      rv_r  <= 1'b0;
      tk_r  <= 1'b0;
    end
    else
    begin
      bit_r <= bit_nxt;
      ws_r  <= ws_nxt;
      tsh_r <= tsh_nxt;
      rsh_r <= rsh_nxt;
      rl_r  <= rl_nxt;
      rr_r  <= rr_nxt;
      sdo_r <= sdo_nxt;
      rv_r  <= rv_nxt;
      tk_r  <= tk_nxt;
    end
  end

  assign lnk.sdo  = sdo_r;
  assign rx_left  = rl_r;
  assign rx_right = rr_r;
  assign rx_valid = rv_r;
  assign tx_take  = tk_r;
endmodule

//--- src/i2s_lane_if.sv
/*
  interface carrying one port's link-facing strobes between the top and a
  lane: sampled clock edges, select level and serial data.
  assumes one core clock for both sides.
*/
`timescale 1ns/1ps
interface i2s_lane_if;
  logic rise;   // bit clock rising edge strobe
  logic fall;   // bit clock falling edge strobe
  logic ws;     // word select level
  logic sdi;    // synchronised serial data in
  logic sdo;    // registered serial data out
  modport top  (output rise, output fall, output ws, output sdi, input sdo);
  modport lane (input rise, input fall, input ws, input sdi, output sdo);
endinterface

//--- tb/i2s_audio_port_sva.sv
/*
  checker for the dual audio port: shared pins and port 0 timing.
  assumes one core_clk domain with synchronous active-low reset.
*/
`timescale 1ns/1ps
module i2s_audio_port_sva
  import i2s_audio_pkg::*;
#(
  parameter int PORTS = 2
)
(
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic [PORTS-1:0] master_en,
  input wire logic [PORTS-1:0] long_frame,
  input wire logic [PORTS-1:0] sck_out,
  input wire logic [PORTS-1:0] sck_oe,
  input wire logic [PORTS-1:0] ws_out,
  input wire logic [PORTS-1:0] ws_oe,
  input wire logic [PORTS-1:0] sdo,
  input wire logic [PORTS-1:0] sdo_oe,
  input wire logic [PORTS-1:0] tx_take,
  input wire logic [PORTS-1:0] rx_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [6:0] hc_r;  // cycles in current clock phase
  logic [6:0] ph_r;  // length of previous phase
  logic [1:0] n_r;   // phases seen; first one is partial
  logic [4:0] fc_r;  // falls since select changed
  logic       sp_r;  // clock last cycle
  logic       wp_r;  // select last cycle
  // phase and fall counters for port 0
  always_ff @(posedge core_clk)
  begin
    sp_r <= sck_out[0];
    wp_r <= ws_out[0];
    hc_r <= (sck_out[0] != sp_r) ? 7'h1 : hc_r + 7'h1;
    if (sck_out[0] != sp_r)
      ph_r <= hc_r;
    if (!rst_n || !master_en[0])
      n_r <= 2'h0;
    else if (sck_out[0] != sp_r && n_r != 2'h2)
      n_r <= n_r + 2'h1;
    if (!rst_n || ws_out[0] != wp_r)
      fc_r <= 5'h0;
    else if (sp_r && !sck_out[0])
      fc_r <= fc_r + 5'h1;
  end
  property p_idle; $rose(rst_n) |-> sck_out == '0 && sdo == '0; endproperty
  a_idle: assert property (p_idle) else $error("lines not idle");
  property p_oe; sdo_oe == '1; endproperty
  a_oe: assert property (p_oe) else $error("sdo not driven");
  property p_dir;
    $stable(master_en) [*3] |-> sck_oe == master_en && ws_oe == master_en;
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction");
  property p_wsf; master_en[0] && $changed(ws_out[0]) |-> $fell(sck_out[0]);
  endproperty
  a_wsf: assert property (p_wsf) else $error("select off fall");
  property p_hold;
    master_en[0] && sck_out[0] && $past(sck_out[0]) |-> $stable(sdo[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("sdo moved high");
  property p_ratio;
    master_en[0] && n_r == 2'h2 && sck_out[0] != sp_r
      |-> hc_r <= ph_r + 7'h1 && ph_r <= hc_r + 7'h1;
  endproperty
  a_ratio: assert property (p_ratio) else $error("mark/space");
  property p_tail;
    master_en[0] && long_frame[0] && fc_r > 5'h11 |-> !sdo[0];
  endproperty
  a_tail: assert property (p_tail) else $error("tail not zero");
  property p_end; master_en[0] && rx_valid[0] |-> !ws_out[0]; endproperty
  a_end: assert property (p_end) else $error("frame end");
  property p_take;
    master_en[0] && tx_take[0] |-> ws_out[0] && !sck_out[0];
  endproperty
  a_take: assert property (p_take) else $error("take outside right");
endmodule
bind i2s_audio_port i2s_audio_port_sva #(.PORTS(PORTS)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .master_en(master_en),
  .long_frame(long_frame), .sck_out(sck_out), .sck_oe(sck_oe),
  .ws_out(ws_out), .ws_oe(ws_oe), .sdo(sdo), .sdo_oe(sdo_oe),
  .tx_take(tx_take), .rx_valid(rx_valid));

//--- tb/i2s_audio_port_test.sv
/*
  bench for the dual audio port: port 0 master short, master long, slave;
  port 1 slave throughout, checked beside it.
  assumes the codec model and checker are compiled first.
*/
`timescale 1ns/1ps
`include "i2s_audio_params.svh"
module i2s_audio_port_test;
  import i2s_audio_pkg::*;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [1:0]       master_en = '0, long_frame = '0;
  logic [1:0][15:0] div_n = '0, div_m = '0, got_l, got_r;
  logic [1:0]       sck_in, sck_out, sck_oe, ws_in, ws_out, ws_oe;
  logic [1:0]       sdo, sdo_oe, sdi, tx_take, rx_valid;
  sample_t [1:0]    tx_left = '0, tx_right = '0, rx_left, rx_right;
  sample_t [1:0]    mdl_l = '0, mdl_r = '0;  // words the codecs send
  int               mismatches = 0;
  int               comparisons = 0;
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  i2s_audio_port DUT (.core_clk(core_clk), .rst_n(rst_n),
    .master_en(master_en), .long_frame(long_frame), .div_n(div_n),
    .div_m(div_m), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .ws_in(ws_in), .ws_out(ws_out), .ws_oe(ws_oe), .sdo(sdo),
    .sdo_oe(sdo_oe), .sdi(sdi), .tx_left(tx_left), .tx_right(tx_right),
    .tx_take(tx_take), .rx_left(rx_left), .rx_right(rx_right),
    .rx_valid(rx_valid));
  // one codec per port
  for (genvar p = 0; p < 2; p++)
  begin : g_far
    i2s_codec_model far (.dev_clk_oe(sck_oe[p]), .sck_dev(sck_out[p]),
      .ws_dev(ws_out[p]), .sdo(sdo[p]), .send_l(mdl_l[p]),
      .send_r(mdl_r[p]), .sck(sck_in[p]), .ws(ws_in[p]), .sdi(sdi[p]),
      .got_l(got_l[p]), .got_r(got_r[p]));
  end
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // frame length may land a cycle or two off the ideal
  task automatic chk_span(input int e, input int g);
    comparisons++;
    if (g < e - 2 || g > e + 2)
    begin
      mismatches++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // mode changes only under reset
  task automatic start(input logic m0, input logic lf,
                       input logic [15:0] n, input logic [15:0] m,
                       input logic [15:0] w);
    @(posedge core_clk);
    rst_n      <= 1'b0;
    master_en  <= {1'b0, m0};
    long_frame <= {1'b0, lf};
    div_n      <= {`I2S_DIV_N_SHORT, n};
    div_m      <= {`I2S_DIV_M_SHORT, m};
    tx_left    <= {~w, w};
    tx_right   <= {w, ~w};
    mdl_l      <= {w ^ 16'h0ff0, ~w};
    mdl_r      <= {w ^ 16'h00ff, w ^ 16'hf000};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  task automatic frames(input int p, input int k);
    int t;
    t = 0;
    while (k > 0 && t < 40000)
    begin
      @(posedge core_clk);
      t++;
      if (rx_valid[p] === 1'b1)
        k--;
    end
    // a hang shows as frames left
    chk(16'h0, k[15:0]);
  endtask
  // cycles and bit clock falls between two select falls on port 0
  task automatic span(input int e, input int b);
    int   c;
    int   f;
    int   s;
    int   n;
    logic q;
    logic h;
    c = 0;
    f = 0;
    s = 0;
    n = 0;
    q = ws_out[0];
    h = sck_out[0];
    while (f < 2 && c < 20000)
    begin
      @(posedge core_clk);
      c++;
      if (f == 1 && h && !sck_out[0])
        n++;
      if (q && !ws_out[0])
      begin
        f++;
        if (f == 1)
          s = c;
      end
      q = ws_out[0];
      h = sck_out[0];
    end
    // a missing second fall must not pass as a frame
    chk_span(e, (f == 2) ? c - s : 0);
    chk(b[15:0], n[15:0]);
  endtask
  task automatic judge;
    for (int p = 0; p < 2; p++)
    begin
      chk(tx_left[p], got_l[p]);
      chk(tx_right[p], got_r[p]);
      chk(mdl_l[p], rx_left[p]);
      chk(mdl_r[p], rx_right[p]);
    end
  endtask
  task automatic test_short;
    start(1'b1, 1'b0, `I2S_DIV_N_SHORT, `I2S_DIV_M_SHORT, 16'h8001);
    span(`I2S_CORE_HZ / `I2S_SAMPLE_HZ, `I2S_FRAME_SHORT);
    frames(0, 2);
    judge;
    $display("test_short finished");
  endtask
  task automatic test_long;
    start(1'b1, 1'b1, `I2S_DIV_N_LONG, `I2S_DIV_M_LONG, 16'h7ffe);
    span(`I2S_CORE_HZ / `I2S_SAMPLE_HZ, `I2S_FRAME_LONG);
    frames(0, 2);
    judge;
    $display("test_long finished");
  endtask
  task automatic test_slave;
    start(1'b0, 1'b0, `I2S_DIV_N_SHORT, `I2S_DIV_M_SHORT, 16'ha55a);
    frames(0, 3);
    judge;
    $display("test_slave finished");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    test_short;
    test_long;
    test_slave;
    end_of_test;
  end
  // about two and a half times the expected run
  initial
  begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    end_of_test;
  end
endmodule

//--- tb/i2s_codec_model.sv
/*
  far-side codec model for one audio port: makes clock and select while
  the port is slave, captures sdo on rising edges, sends sdi words.
  assumes dev_clk_oe is the port's clock output enable.
*/
`timescale 1ns/1ps
module i2s_codec_model
#(
  parameter int HALF_NS = 164  // 3.05 MHz, under the slave ceiling
)
(
  input  wire logic        dev_clk_oe,
  input  wire logic        sck_dev,
  input  wire logic        ws_dev,
  input  wire logic        sdo,
  input  wire logic [15:0] send_l,
  input  wire logic [15:0] send_r,
  output logic             sck,
  output logic             ws,
  output logic             sdi,
  output logic [15:0]      got_l,
  output logic [15:0]      got_r
);
  logic        oclk = 1'b0;   // own bit clock, free running
  logic        ows  = 1'b0;   // own select
  logic [3:0]  oc   = 4'h0;   // falls in this half
  logic        wsp  = 1'b0;   // select seen at last rise
  logic [4:0]  cnt  = 5'h10;  // bits taken this half
  logic [15:0] sh;            // capture shifter
  logic [15:0] wd;            // word being sent
  assign wd  = wsp ? send_r : send_l;
  // pin owner follows the port's enable
  assign sck = dev_clk_oe ? sck_dev : oclk;
  assign ws  = dev_clk_oe ? ws_dev : ows;
  always #(HALF_NS) oclk = ~oclk;
  // select flips every sixteen falls
  always @(negedge oclk)
  begin
    oc <= oc + 4'h1;
    if (oc == 4'hf)
      ows <= ~ows;
  end
  // sample on rise; only the first sixteen bits count
  always @(posedge sck)
  begin
    wsp <= ws;
    if (cnt < 5'h10)
    begin
      sh  <= {sh[14:0], sdo};
      cnt <= cnt + 5'h1;
      if (cnt == 5'hf && wsp)
        got_r <= {sh[14:0], sdo};
      if (cnt == 5'hf && !wsp)
        got_l <= {sh[14:0], sdo};
    end
    if (ws != wsp)
      cnt <= 5'h0;
  end
  // msb one slot after select; noise past sixteen bits
  always @(negedge sck)
    sdi <= (cnt < 5'h10) ? wd[4'hf - cnt[3:0]] : ~sdi;
endmodule
